//--- src/dcache_pkg.sv
// Behaviour
// - four ways of 256 lines; one set index selects a line in every way
// - tag holds physical address bits [28:10]; tags are never reset
// - valid flag cleared by power-on reset, kept through manual reset
// - dirty flag set on copy-back write hit, never by write-through
// - dirty flag cleared by power-on reset, kept through manual reset
// - each line holds 32 bytes; data array is never reset
// - six pairwise age bits per set pick the least recently used victim
// - age bits cleared by power-on reset only; software cannot reach them
// - lookup and allocation only when cache enabled and region cacheable
// - set chosen by virtual address bits [12:5], all ways read together
// - hit needs a matching tag against physical bits [28:10] and valid set
// - load hit returns sized data at offset [4:0] and makes way newest
// - load or prefetch miss fills the victim in wraparound order, critical quad-word first
// - load miss data forwarded on arrival; processor continues during fill
// - after fill write tag, set valid, clear dirty, make way newest
// - dirty victim copied to write-back buffer, written out after refill
// - prefetch uses load lookup; a prefetch hit only updates age bits
// - prefetch miss fills without holding the processor, no data returned
// - control register write with refetch select 0 refetches next instr
package dcache_pkg;

    localparam int WAYS       = 4;
    localparam int SETS       = 256;
    localparam int BEATS      = 4;
    localparam int BEAT_W     = 64;
    localparam int LINE_BYTES = 32;
    localparam int PA_W       = 29;
    localparam int VA_W       = 13;
    localparam int TAG_W      = 19;
    localparam int TAG_LSB    = 10;
    localparam int SET_W      = 8;
    localparam int SET_LSB    = 5;
    localparam int QUAD_LSB   = 3;
    localparam int LRU_W      = 6;
    localparam int WAY_W      = 2;
    localparam int BEAT_IDX_W = 2;

    localparam logic [LRU_W-1:0]      LRU_RESET  = 6'h00;
    localparam logic [BEAT_IDX_W-1:0] LAST_COUNT = 2'h3;

    typedef enum logic [1:0] {
        KIND_LOAD,
        KIND_PREFETCH,
        KIND_STORE
    } req_kind_e;

    // size codes: byte, word, long, quad
    typedef struct packed {
        logic              valid;
        req_kind_e         kind;
        logic [1:0]        size;
        logic              cacheable;
        logic              write_through;
        logic [VA_W-1:0]   vaddr;
        logic [PA_W-1:0]   paddr;
        logic [BEAT_W-1:0] wdata;
        logic [7:0]        wstrb;
    } cpu_req_s;

    typedef struct packed {
        logic              done;
        logic              uncached;
        logic [BEAT_W-1:0] data;
    } cpu_resp_s;

    typedef struct packed {
        logic            req;
        logic [PA_W-1:0] addr;
    } mem_rd_s;

    typedef struct packed {
        logic              valid;
        logic [PA_W-1:0]   addr;
        logic [BEAT_W-1:0] data;
        logic              last;
    } mem_wr_s;

endpackage : dcache_pkg

//--- src/data_cache.sv
`timescale 1ns/1ps
module data_cache
    import dcache_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              manual_reset,
    input  wire logic              data_cache_enable,
    input  wire logic              refetch_select_bit,
    input  wire logic              cache_control_write,
    input  wire cpu_req_s          cpu_req,
    output cpu_resp_s              cpu_resp,
    output logic                   refetch_next,
    output mem_rd_s                mem_rd,
    input  wire logic              mem_rd_accept,
    input  wire logic              mem_rd_beat_valid,
    input  wire logic [BEAT_W-1:0] mem_rd_beat_data,
    output mem_wr_s                mem_wr,
    input  wire logic              mem_wr_ready
);

    // ****************************************************************
    // age bits: pairs (0,1)(0,2)(0,3)(1,2)(1,3)(2,3); a set bit means
    // the lower way of the pair was used more recently
    // ****************************************************************
    function automatic logic [WAY_W-1:0] lru_victim(input logic [LRU_W-1:0] s);
        logic [WAY_W-1:0] v;
        logic             ok;
        int               p;
        v = '0;
        for (int w = WAYS - 1; w >= 0; w--) begin
            ok = 1'b1;
            p  = 0;
            for (int i = 0; i < WAYS - 1; i++) begin
                for (int j = i + 1; j < WAYS; j++) begin
                    if (i == w && s[p])
                        ok = 1'b0;
                    if (j == w && !s[p])
                        ok = 1'b0;
                    p++;
                end
            end
            if (ok)
                v = WAY_W'(w);
        end
        return v;
    endfunction : lru_victim

    function automatic logic [LRU_W-1:0] lru_touch(input logic [LRU_W-1:0] s,
                                                   input logic [WAY_W-1:0] w);
        logic [LRU_W-1:0] r;
        int               p;
        r = s;
        p = 0;
        for (int i = 0; i < WAYS - 1; i++) begin
            for (int j = i + 1; j < WAYS; j++) begin
                if (WAY_W'(i) == w)
                    r[p] = 1'b1;
                if (WAY_W'(j) == w)
                    r[p] = 1'b0;
                p++;
            end
        end
        return r;
    endfunction : lru_touch

    // align the addressed item to bit 0 and clear the bytes beyond its size
    function automatic logic [BEAT_W-1:0] size_data(input logic [BEAT_W-1:0] d,
                                                    input logic [2:0]        off,
                                                    input logic [1:0]        size);
        logic [BEAT_W-1:0] sh;
        sh = d >> {off, 3'h0};
        unique case (size)
            2'h0: size_data = {56'h0, sh[7:0]};
            2'h1: size_data = {48'h0, sh[15:0]};
            2'h2: size_data = {32'h0, sh[31:0]};
            2'h3: size_data = sh;
        endcase
    endfunction : size_data

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [TAG_W-1:0]  tag_mem   [WAYS][SETS];
    logic [BEAT_W-1:0] data_mem  [WAYS][SETS][BEATS];
    logic              valid_reg [WAYS][SETS];
    logic              dirty_reg [WAYS][SETS];
    logic [LRU_W-1:0]  lru_reg   [SETS];

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ_REQ,
        ST_FILL
    } fill_state_e;

    fill_state_e             state_reg;
    logic [SET_W-1:0]        fill_set_reg;
    logic [WAY_W-1:0]        fill_way_reg;
    logic [TAG_W-1:0]        fill_tag_reg;
    logic [BEAT_IDX_W-1:0]   fill_beat_reg;
    logic [BEAT_IDX_W-1:0]   fill_count_reg;
    logic                    fill_load_reg;
    logic [2:0]              fill_off_reg;
    logic [1:0]              fill_size_reg;

    logic                    wb_full_reg;
    logic                    wb_go_reg;
    logic [TAG_W-1:0]        wb_tag_reg;
    logic [SET_W-1:0]        wb_set_reg;
    logic [BEAT_W-1:0]       wb_data_reg [BEATS];
    logic [BEAT_IDX_W-1:0]   wb_beat_reg;

    // ****************************************************************
    // lookup
    // ****************************************************************
    logic [SET_W-1:0]      set_idx;
    logic [TAG_W-1:0]      req_tag;
    logic [BEAT_IDX_W-1:0] req_quad;
    logic [WAYS-1:0]       hit_vec;
    logic                  hit;
    logic [WAY_W-1:0]      hit_way;
    logic [WAY_W-1:0]      victim_way;
    logic                  victim_dirty;
    logic                  cached;
    logic                  set_busy;
    logic                  acc_bypass;
    logic                  acc_hit;
    logic                  acc_miss;
    logic                  acc_store_miss;
    logic                  beat_take;
    logic                  fill_done;
    logic [BEAT_W-1:0]     hit_beat;
    logic [BEAT_W-1:0]     store_beat;

    assign set_idx  = cpu_req.vaddr[SET_LSB +: SET_W];
    assign req_tag  = cpu_req.paddr[TAG_LSB +: TAG_W];
    assign req_quad = cpu_req.vaddr[QUAD_LSB +: BEAT_IDX_W];

    for (genvar w = 0; w < WAYS; w++) begin : g_cmp
        assign hit_vec[w] = valid_reg[w][set_idx] && (tag_mem[w][set_idx] == req_tag);
    end

    always_comb begin
        hit_way = '0;
        for (int w = 0; w < WAYS; w++) begin
            if (hit_vec[w])
                hit_way = WAY_W'(w);
        end
    end

    assign hit          = |hit_vec;
    assign victim_way   = lru_victim(lru_reg[set_idx]);
    assign victim_dirty = valid_reg[victim_way][set_idx] && dirty_reg[victim_way][set_idx];
    assign cached       = data_cache_enable && cpu_req.cacheable;
    assign hit_beat     = data_mem[hit_way][set_idx][req_quad];

    // a set with a fill in flight or a line parked for write-back waits
    assign set_busy = ((state_reg != ST_IDLE) && (set_idx == fill_set_reg))
                    || (wb_full_reg && (set_idx == wb_set_reg));

    always_comb begin
        acc_bypass     = 1'b0;
        acc_hit        = 1'b0;
        acc_miss       = 1'b0;
        acc_store_miss = 1'b0;
        if (cpu_req.valid && !cpu_resp.done && !manual_reset) begin
            if (!cached)
                acc_bypass = 1'b1;
            else if (!set_busy && hit)
                acc_hit = 1'b1;
            else if (!set_busy && cpu_req.kind == KIND_STORE)
                acc_store_miss = 1'b1;
            else if (!set_busy && state_reg == ST_IDLE && !(victim_dirty && wb_full_reg))
                acc_miss = 1'b1;
        end
    end

    always_comb begin
        store_beat = hit_beat;
        for (int b = 0; b < 8; b++) begin
            if (cpu_req.wstrb[b])
                store_beat[b*8 +: 8] = cpu_req.wdata[b*8 +: 8];
        end
    end

    assign beat_take = (state_reg == ST_FILL) && mem_rd_beat_valid;
    assign fill_done = beat_take && (fill_count_reg == LAST_COUNT);

    // ****************************************************************
    // arrays without reset: tags and data
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (acc_hit && cpu_req.kind == KIND_STORE)
            data_mem[hit_way][set_idx][req_quad] <= store_beat;
        if (beat_take)
            data_mem[fill_way_reg][fill_set_reg][fill_beat_reg] <= mem_rd_beat_data;
        if (fill_done)
            tag_mem[fill_way_reg][fill_set_reg] <= fill_tag_reg;
    end

    // ****************************************************************
    // line state: power-on reset only, manual reset leaves it alone
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int w = 0; w < WAYS; w++) begin
                for (int s = 0; s < SETS; s++) begin
                    valid_reg[w][s] <= 1'b0;
                    dirty_reg[w][s] <= 1'b0;
                end
            end
        end else begin
            // the victim goes invalid while its beats arrive
            if (acc_miss && cpu_req.kind != KIND_STORE)
                valid_reg[victim_way][set_idx] <= 1'b0;
            if (acc_hit && cpu_req.kind == KIND_STORE && !cpu_req.write_through)
                dirty_reg[hit_way][set_idx] <= 1'b1;
            if (fill_done) begin
                valid_reg[fill_way_reg][fill_set_reg] <= 1'b1;
                dirty_reg[fill_way_reg][fill_set_reg] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < SETS; s++)
                lru_reg[s] <= LRU_RESET;
        end else begin
            if (acc_hit)
                lru_reg[set_idx] <= lru_touch(lru_reg[set_idx], hit_way);
            if (fill_done)
                lru_reg[fill_set_reg] <= lru_touch(lru_reg[fill_set_reg], fill_way_reg);
        end
    end

    // ****************************************************************
    // line fill sequencer
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= ST_IDLE;
            fill_set_reg   <= '0;
            fill_way_reg   <= '0;
            fill_tag_reg   <= '0;
            fill_beat_reg  <= '0;
            fill_count_reg <= '0;
            fill_load_reg  <= 1'b0;
            fill_off_reg   <= '0;
            fill_size_reg  <= '0;
            mem_rd         <= '0;
        end else if (manual_reset) begin
            state_reg <= ST_IDLE;
            mem_rd    <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (acc_miss) begin
                        state_reg      <= ST_READ_REQ;
                        fill_set_reg   <= set_idx;
                        fill_way_reg   <= victim_way;
                        fill_tag_reg   <= req_tag;
                        fill_beat_reg  <= req_quad;
                        fill_count_reg <= '0;
                        fill_load_reg  <= (cpu_req.kind == KIND_LOAD);
                        fill_off_reg   <= cpu_req.vaddr[2:0];
                        fill_size_reg  <= cpu_req.size;
                        mem_rd.req     <= 1'b1;
                        mem_rd.addr    <= {cpu_req.paddr[PA_W-1:QUAD_LSB], 3'h0};
                    end
                end
                ST_READ_REQ: begin
                    if (mem_rd_accept) begin
                        mem_rd.req <= 1'b0;
                        state_reg  <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (beat_take) begin
                        fill_beat_reg  <= fill_beat_reg + 2'h1;
                        fill_count_reg <= fill_count_reg + 2'h1;
                        if (fill_done)
                            state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // processor answers
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_resp <= '0;
        end else if (manual_reset) begin
            cpu_resp <= '0;
        end else begin
            cpu_resp.done     <= 1'b0;
            cpu_resp.uncached <= 1'b0;
            if (acc_bypass) begin
                cpu_resp.done     <= 1'b1;
                cpu_resp.uncached <= 1'b1;
                cpu_resp.data     <= '0;
            end else if (acc_hit || acc_store_miss) begin
                cpu_resp.done <= 1'b1;
                cpu_resp.data <= (cpu_req.kind == KIND_LOAD)
                               ? size_data(hit_beat, cpu_req.vaddr[2:0], cpu_req.size)
                               : '0;
            end else if (acc_miss && cpu_req.kind == KIND_PREFETCH) begin
                cpu_resp.done <= 1'b1;
                cpu_resp.data <= '0;
            end else if (beat_take && fill_count_reg == '0 && fill_load_reg) begin
                // critical quad is the first beat; the rest fill behind the cpu
                cpu_resp.done <= 1'b1;
                cpu_resp.data <= size_data(mem_rd_beat_data, fill_off_reg, fill_size_reg);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            refetch_next <= 1'b0;
        else
            refetch_next <= cache_control_write && !refetch_select_bit;
    end

    // ****************************************************************
    // write-back buffer: one line, drained after the refill ends or on manual reset
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (acc_miss && victim_dirty) begin
            wb_tag_reg <= tag_mem[victim_way][set_idx];
            wb_set_reg <= set_idx;
            for (int b = 0; b < BEATS; b++)
                wb_data_reg[b] <= data_mem[victim_way][set_idx][b];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_full_reg <= 1'b0;
            wb_go_reg   <= 1'b0;
            wb_beat_reg <= '0;
            mem_wr      <= '0;
        end else begin
            if (acc_miss && victim_dirty) begin
                wb_full_reg <= 1'b1;
                wb_beat_reg <= '0;
            end
            if ((fill_done || manual_reset) && wb_full_reg)
                wb_go_reg <= 1'b1;
            if (wb_go_reg && !mem_wr.valid && wb_beat_reg == '0) begin
                mem_wr.valid <= 1'b1;
                mem_wr.addr  <= {wb_tag_reg, wb_set_reg[TAG_LSB-SET_LSB-1:0], 5'h00};
                mem_wr.data  <= wb_data_reg[0];
                mem_wr.last  <= 1'b0;
                wb_beat_reg  <= 2'h1;
            end else if (mem_wr.valid && mem_wr_ready) begin
                if (mem_wr.last) begin
                    mem_wr.valid <= 1'b0;
                    mem_wr.last  <= 1'b0;
                    wb_full_reg  <= 1'b0;
                    wb_go_reg    <= 1'b0;
                    wb_beat_reg  <= '0;
                end else begin
                    mem_wr.addr <= mem_wr.addr + PA_W'(8);
                    mem_wr.data <= wb_data_reg[wb_beat_reg];
                    mem_wr.last <= (wb_beat_reg == LAST_COUNT);
                    wb_beat_reg <= wb_beat_reg + 2'h1;
                end
            end
        end
    end

endmodule : data_cache

//--- sim/data_cache_asserts.sv
`timescale 1ns/1ps
// **********
// port rules
// **********
module data_cache_asserts
    import dcache_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic manual_reset,
    input wire logic data_cache_enable,
    input wire logic refetch_select_bit,
    input wire logic cache_control_write,
    input cpu_req_s  cpu_req,
    input cpu_resp_s cpu_resp,
    input wire logic refetch_next,
    input mem_rd_s   mem_rd,
    input wire logic mem_rd_accept,
    input mem_wr_s   mem_wr,
    input wire logic mem_wr_ready
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence unc_req;
        cpu_req.valid && !cpu_resp.done && !manual_reset && !data_cache_enable;
    endsequence
    sequence wr_stall;
        mem_wr.valid && !mem_wr_ready;
    endsequence
    done_pulse_a: assert property (cpu_resp.done |=> !cpu_resp.done)
        else $error("done stood longer than one cycle");
    uncached_ans_a: assert property (unc_req ##1 !manual_reset
        |-> cpu_resp.done && cpu_resp.uncached) else $error("disabled access not answered");
    refetch_on_a:
        assert property (cache_control_write && !refetch_select_bit |=> refetch_next)
        else $error("refetch pulse missing");
    refetch_off_a:
        assert property (!(cache_control_write && !refetch_select_bit) |=> !refetch_next)
        else $error("unexpected refetch pulse");
    rd_align_a: assert property (mem_rd.req |-> mem_rd.addr[2:0] == 3'h0)
        else $error("read not quad aligned");
    rd_hold_a: assert property (mem_rd.req && !mem_rd_accept && !manual_reset
        |=> mem_rd.req && $stable(mem_rd.addr)) else $error("read request dropped");
    wr_hold_a: assert property (wr_stall |=> mem_wr.valid && $stable(mem_wr.addr))
        else $error("write beat changed while stalled");
    wr_base_a: assert property ($rose(mem_wr.valid) |-> mem_wr.addr[4:0] == 5'h00)
        else $error("write-back not from line base");
    wr_last_a: assert property (mem_wr.valid && mem_wr.last |-> mem_wr.addr[4:0] == 5'h18)
        else $error("last beat misplaced");
    mreset_quiet_a: assert property (manual_reset |=> !cpu_resp.done && !mem_rd.req)
        else $error("manual reset left outputs active");
    nodata_a: assert property (cpu_resp.done && $past(cpu_req.kind) != KIND_LOAD
        |-> cpu_resp.data == 64'h0) else $error("data returned for non-load");
endmodule : data_cache_asserts
bind data_cache data_cache_asserts checker_i (.clock(clock), .rst_n(rst_n),
    .manual_reset(manual_reset), .data_cache_enable(data_cache_enable),
    .refetch_select_bit(refetch_select_bit), .cache_control_write(cache_control_write),
    .cpu_req(cpu_req), .cpu_resp(cpu_resp), .refetch_next(refetch_next), .mem_rd(mem_rd),
    .mem_rd_accept(mem_rd_accept), .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready));

//--- sim/mem_model.sv
`timescale 1ns/1ps
// ************
// memory model
// ************
module mem_model
    import dcache_pkg::*;
(
    input wire logic          clock,
    input wire logic          rst_n,
    input wire logic          slow,
    input mem_rd_s            mem_rd,
    output logic              mem_rd_accept,
    output logic              mem_rd_beat_valid,
    output logic [BEAT_W-1:0] mem_rd_beat_data,
    output logic              mem_wr_ready
);
    logic [PA_W-1:0] base_reg;
    logic [1:0]      beat_reg;
    logic            busy_reg;
    logic            lag_reg;
    function automatic logic [BEAT_W-1:0] quad(input logic [PA_W-1:0] p);
        return {3'h0, ~p, 3'h0, p};
    endfunction : quad
    // slow mode stalls every other cycle, reads and writes alike
    assign mem_wr_ready = !(slow && lag_reg);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg          <= 1'b0;
            beat_reg          <= 2'h0;
            lag_reg           <= 1'b0;
            base_reg          <= '0;
            mem_rd_accept     <= 1'b0;
            mem_rd_beat_valid <= 1'b0;
            mem_rd_beat_data  <= '0;
        end else begin
            lag_reg           <= !lag_reg;
            mem_rd_accept     <= mem_rd.req && !mem_rd_accept && !busy_reg && !(slow && lag_reg);
            mem_rd_beat_valid <= 1'b0;
            // an idle data line flips so a stale beat can never match
            mem_rd_beat_data  <= ~mem_rd_beat_data;
            if (mem_rd.req && mem_rd_accept) begin
                busy_reg <= 1'b1;
                base_reg <= mem_rd.addr;
                beat_reg <= 2'h0;
            end
            if (busy_reg && !(slow && lag_reg)) begin
                mem_rd_beat_valid <= 1'b1;
                mem_rd_beat_data  <= quad({base_reg[28:5], base_reg[4:3] + beat_reg, 3'h0});
                beat_reg          <= beat_reg + 2'h1;
                busy_reg          <= beat_reg != 2'h3;
            end
        end
    end
endmodule : mem_model

//--- sim/tb_data_cache.sv
`timescale 1ns/1ps
// ****************
// data cache bench
// ****************
module tb_data_cache;
    import dcache_pkg::*;
    localparam logic [47:0] TAGS = 48'h513241514321;
    localparam logic [11:0] MISSES = 12'hb2f;
    logic clock = 1'b0, rst_n = 1'b0, manual_reset = 1'b0, slow = 1'b0;
    logic data_cache_enable = 1'b1, refetch_select_bit = 1'b0, cache_control_write = 1'b0;
    logic cach = 1'b1, wt = 1'b0, miss, refetch_next, acc, beat_v, wr_rdy;
    cpu_req_s        cpu_req = '0;
    cpu_resp_s       cpu_resp;
    mem_rd_s         mem_rd;
    mem_wr_s         mem_wr;
    logic [63:0]     beat_d;
    logic [63:0]     wr_log [4];
    logic [PA_W-1:0] rd_addr, a;
    logic [1:0]      sz;
    logic [31:0]     lfsr = 32'h00012f45;
    int err_total = 0, tests_run = 0, cyc = 0, rd_cnt = 0, wr_beats = 0, lat, b;
    always #12.5 clock = ~clock;
    data_cache dut (.clock(clock), .rst_n(rst_n), .manual_reset(manual_reset),
        .data_cache_enable(data_cache_enable), .refetch_select_bit(refetch_select_bit),
        .cache_control_write(cache_control_write), .cpu_req(cpu_req), .cpu_resp(cpu_resp),
        .refetch_next(refetch_next), .mem_rd(mem_rd), .mem_rd_accept(acc),
        .mem_rd_beat_valid(beat_v), .mem_rd_beat_data(beat_d), .mem_wr(mem_wr),
        .mem_wr_ready(wr_rdy));
    mem_model pm (.clock(clock), .rst_n(rst_n), .slow(slow), .mem_rd(mem_rd),
        .mem_rd_accept(acc), .mem_rd_beat_valid(beat_v), .mem_rd_beat_data(beat_d),
        .mem_wr_ready(wr_rdy));
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nx
    function automatic logic [63:0] exp_ld(input logic [PA_W-1:0] p, input logic [1:0] s);
        logic [63:0] q;
        q = {3'h0, ~{p[28:3], 3'h0}, 3'h0, p[28:3], 3'h0} >> {p[2:0], 3'h0};
        return q & ((64'h1 << (7'h08 << s)) - 64'h1);
    endfunction : exp_ld
    function automatic logic [PA_W-1:0] ln(input int t, input int w);
        return {12'h0, t[3:0], 7'h40, w[0], 5'h00};
    endfunction : ln
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        if (err_total == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task automatic acc_op(input req_kind_e k, input logic [PA_W-1:0] p, input logic [1:0] s,
                          input logic [63:0] wd);
        int n;
        int r0;
        n  = 0;
        r0 = rd_cnt;
        @(negedge clock);
        cpu_req = {1'b1, k, s, cach, wt, p[12:0], p, wd, 8'hff};
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (cpu_resp.done !== 1'b1);
        lat  = n;
        miss = rd_cnt != r0;
        if (!(cach && data_cache_enable)) chk(cpu_resp.uncached, 1'b1);
        else chk(cpu_resp.data, k == KIND_LOAD ? exp_ld(p, s) : 64'h0);
        @(negedge clock);
        cpu_req.valid = 1'b0;
    endtask : acc_op
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (mem_rd.req && acc) rd_cnt <= rd_cnt + 1;
        if (mem_rd.req && acc) rd_addr <= mem_rd.addr;
        if (mem_wr.valid && wr_rdy) wr_beats <= wr_beats + 1;
        if (mem_wr.valid && wr_rdy) wr_log[mem_wr.addr[4:3]] <= mem_wr.data;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        a = {12'h0, 4'h1, 8'h03, 5'h12};
        acc_op(KIND_LOAD, a, 2'h2, '0);
        chk(miss, 1'b1);
        chk(rd_addr, {a[28:3], 3'h0});
        acc_op(KIND_LOAD, {a[28:5], 5'h08}, 2'h3, '0);
        chk(miss, 1'b0);
        @(negedge clock);
        manual_reset = 1'b1;
        @(negedge clock);
        manual_reset = 1'b0;
        acc_op(KIND_LOAD, a, 2'h0, '0);
        chk(miss, 1'b0);
        for (int v = 0; v < 2; v++) begin
            @(negedge clock);
            refetch_select_bit = v[0];
            cache_control_write = 1'b1;
            @(negedge clock);
            cache_control_write = 1'b0;
            chk(refetch_next, !v[0]);
        end
        // a prefetch miss answers at once; the fill still lands for the next load
        b = rd_cnt;
        acc_op(KIND_PREFETCH, ln(2, 0) - 29'h400, 2'h3, '0);
        chk(lat, 1);
        acc_op(KIND_LOAD, ln(2, 0) - 29'h400, 2'h3, '0);
        acc_op(KIND_PREFETCH, ln(2, 0) - 29'h400, 2'h3, '0);
        chk(rd_cnt - b, 1);
        for (int v = 0; v < 2; v++) begin
            data_cache_enable = v[0];
            cach = !v[0];
            b = rd_cnt;
            acc_op(KIND_LOAD, {12'h0, 4'h9, 8'h44, 5'h00}, 2'h2, '0);
            chk(rd_cnt - b, 0);
        end
        data_cache_enable = 1'b1;
        cach = 1'b1;
        slow = 1'b1;
        for (int i = 0; i < 12; i++) begin
            acc_op(KIND_LOAD, {12'h0, TAGS[i*4 +: 4], 8'h40, 5'h10}, 2'h1, '0);
            chk(miss, MISSES[i]);
        end
        // the sixth load waits on the buffer's set, so the burst is over by then
        for (int w = 0; w < 2; w++) begin
            b = wr_beats;
            acc_op(KIND_LOAD, ln(1, w), 2'h3, '0);
            wt = w[0];
            acc_op(KIND_STORE, ln(1, w), 2'h3, 64'h0123456789abcdef);
            wt = 1'b0;
            for (int t = 2; t < 7; t++) acc_op(KIND_LOAD, ln(t, w), 2'h3, '0);
            chk(wr_beats - b, w ? 0 : 4);
            if (w == 0) chk(wr_log[0], 64'h0123456789abcdef);
        end
        for (int i = 0; i < 40; i++) begin
            lfsr = nx(lfsr);
            slow = lfsr[20];
            sz   = lfsr[12:11];
            a    = {12'h0, 1'b1, lfsr[2:0], lfsr[10:3], lfsr[17:13] & ~((5'h01 << sz) - 5'h01)};
            acc_op(lfsr[21] ? KIND_PREFETCH : KIND_LOAD, a, sz, '0);
        end
        @(negedge clock);
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        acc_op(KIND_LOAD, a, sz, '0);
        chk(miss, 1'b1);
        tally_and_finish();
    end
endmodule : tb_data_cache
